// [verilog/simd_consts.svh]
// constants for the sub-word dot, permute and pack unit
// assumes inclusion by the dot, permute and pack datapath module only
// Operation
// - halfword dot: lane0*lane0 plus lane1*lane1 of source 1 and operand 2
// - byte dot: sum of four lane-wise byte products, lanes 0 to 3
// - unsigned dot variants zero-extend every lane of both operands
// - signed dot variants treat every lane as two's complement
// - mixed dot variants: source 1 lanes unsigned, operand 2 lanes signed
// - accumulating dot variants add the products to the old destination
// - lane put replaces only the chosen lane with source 1 low lane
// - byte pack upper fills bits 31:16, lower fills 15:0, rest kept
// - immediate permute: byte 2 by imm 5:4, byte 3 fixed by variant
// - immediate permute: byte 1 by imm 3:2, byte 0 by imm 1:0
// - two-source permute low half: source by bit 1, half by bit 0
// - two-source permute high half: source by bit 17, half by bit 16
// - two-source byte 0: source by bit 2, index by bits 1:0
// - two-source byte 1 uses bit 10, bits 9:8; byte 2 bit 18, 17:16
// - two-source byte 3: source by bit 26, index by bits 25:24
// - scalar replicate repeats lowest lane of source 2 across operand 2
// - immediate replicate sign-extends immediate per lane unless zero ext
// - lane 0 is bits 15:0 or 7:0, higher indices go upward
// - operations exist only when the custom extension enable equals 1
`ifndef SIMD_CONSTS_SVH
`define SIMD_CONSTS_SVH
`define RESULT_RST_VAL 32'h0000_0000
`define HALF_SEL_LO 0
`define HALF_SRC_LO 1
`define HALF_SEL_HI 16
`define HALF_SRC_HI 17
`define BYTE_IDX0 0
`define BYTE_SRC0 2
`define BYTE_IDX1 8
`define BYTE_SRC1 10
`define BYTE_IDX2 16
`define BYTE_SRC2 18
`define BYTE_IDX3 24
`define BYTE_SRC3 26
`define IMM_IDX0 0
`define IMM_IDX1 2
`define IMM_IDX2 4
`endif

// [verilog/simd_pkg.sv]
// types shared by the sub-word datapath files
// assumes the constants header sits beside it
package simd_pkg;
  typedef enum logic [4:0] {
    OP_LANE_GET_SIGNED = 5'h00,
    OP_LANE_GET_UNSIGNED = 5'h01,
    OP_LANE_PUT = 5'h02,
    OP_DOT_UNSIGNED = 5'h03,
    OP_DOT_MIXED_SIGN = 5'h04,
    OP_DOT_SIGNED = 5'h05,
    OP_DOT_ACCUM_UNSIGNED = 5'h06,
    OP_DOT_ACCUM_MIXED_SIGN = 5'h07,
    OP_DOT_ACCUM_SIGNED = 5'h08,
    OP_LANE_PERMUTE = 5'h09,
    OP_LANE_PERMUTE_IMM = 5'h0A,
    OP_TWO_SOURCE_PERMUTE = 5'h0B,
    OP_HALFWORD_PACK = 5'h0C,
    OP_HALFWORD_PACK_HIGH = 5'h0D,
    OP_BYTE_PACK_UPPER = 5'h0E,
    OP_BYTE_PACK_LOWER = 5'h0F
  } op_t;
  typedef enum logic [1:0] {
    MODE_VECTOR = 2'h0,
    MODE_SCALAR_REPLICATE = 2'h1,
    MODE_IMM_REPLICATE = 2'h2
  } mode_t;
  typedef enum logic {
    WIDTH_HALF = 1'h0,
    WIDTH_BYTE = 1'h1
  } width_t;
endpackage

// [verilog/simd_operand_builder.sv]
// builds operand 2 from source 2 or the immediate
// assumes mode and width come straight from decode
`timescale 1ns/1ps
module simd_operand_builder (
  input wire simd_pkg::mode_t mode,
  input wire simd_pkg::width_t width,
  input wire logic imm_zext,
  input wire logic [31:0] src2,
  input wire logic [5:0] imm,
  output logic [31:0] op2
);
  logic [15:0] imm_half;
  logic [7:0] imm_byte;

  always_comb begin
    imm_half = {{10{imm[5] & ~imm_zext}}, imm};
    imm_byte = {{2{imm[5] & ~imm_zext}}, imm};
    case (mode)
      simd_pkg::MODE_SCALAR_REPLICATE: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          op2 = {2{src2[15:0]}};
        end else begin
          op2 = {4{src2[7:0]}};
        end
      end
      simd_pkg::MODE_IMM_REPLICATE: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          op2 = {2{imm_half}};
        end else begin
          op2 = {4{imm_byte}};
        end
      end
      default: begin
        op2 = src2;
      end
    endcase
  end
endmodule // simd_operand_builder

// [verilog/simd_dot_shuffle_pack_unit.sv]
// sub-word dot product, lane access, permute and pack datapath slice
// assumes operands are stable in the cycle op_valid is high
`timescale 1ns/1ps
`include "simd_consts.svh"
module simd_dot_shuffle_pack_unit #(
  parameter bit CUSTOM_EXT_ENABLE = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire simd_pkg::op_t op,
  input wire simd_pkg::mode_t mode,
  input wire simd_pkg::width_t width,
  input wire logic imm_zext,
  input wire logic [1:0] permute_variant,
  input wire logic [5:0] imm,
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic [31:0] dest_old,
  output logic [31:0] result_q,
  output logic result_valid_q,
  output logic illegal_q
);
  logic [31:0] op2;
  logic [31:0] res_d;
  logic sgn1;
  logic sgn2;
  logic accum;
  logic signed [17:0] bprod [4];
  logic signed [33:0] hprod [2];
  logic [31:0] dot_b;
  logic [31:0] dot_h;
  logic [31:0] dot_sum;
  logic [15:0] half_pick;
  logic [7:0] byte_pick;

  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0] i);
    case (i)
      2'h0: pick_byte = w[7:0];
      2'h1: pick_byte = w[15:8];
      2'h2: pick_byte = w[23:16];
      default: pick_byte = w[31:24];
    endcase
  endfunction

  function automatic logic [15:0] pick_half(input logic [31:0] w,
                                            input logic i);
    pick_half = i ? w[31:16] : w[15:0];
  endfunction

  simd_operand_builder u_op2 (
    .mode(mode),
    .width(width),
    .imm_zext(imm_zext),
    .src2(src2),
    .imm(imm),
    .op2(op2)
  );

  // lane get indexes from the immediate, never from operand 2,
  // so a replicate mode cannot disturb the lane choice
  always_comb begin
    half_pick = pick_half(src1, imm[0]);
    byte_pick = pick_byte(src1, imm[1:0]);
  end

  // signedness and accumulate decode
  always_comb begin
    sgn1 = (op == simd_pkg::OP_DOT_SIGNED) ||
           (op == simd_pkg::OP_DOT_ACCUM_SIGNED);
    sgn2 = sgn1 || (op == simd_pkg::OP_DOT_MIXED_SIGN) ||
           (op == simd_pkg::OP_DOT_ACCUM_MIXED_SIGN);
    accum = (op == simd_pkg::OP_DOT_ACCUM_UNSIGNED) ||
            (op == simd_pkg::OP_DOT_ACCUM_MIXED_SIGN) ||
            (op == simd_pkg::OP_DOT_ACCUM_SIGNED);
  end

  // one extra bit per lane lets one signed multiplier serve all signs
  for (genvar gi = 0; gi < 4; gi++) begin : g_byte_mul
    logic signed [8:0] a;
    logic signed [8:0] b;
    assign a = {sgn1 & src1[8*gi+7], src1[8*gi +: 8]};
    assign b = {sgn2 & op2[8*gi+7], op2[8*gi +: 8]};
    assign bprod[gi] = a * b;
  end

  for (genvar gh = 0; gh < 2; gh++) begin : g_half_mul
    logic signed [16:0] a;
    logic signed [16:0] b;
    assign a = {sgn1 & src1[16*gh+15], src1[16*gh +: 16]};
    assign b = {sgn2 & op2[16*gh+15], op2[16*gh +: 16]};
    assign hprod[gh] = a * b;
  end

  // sums wrap at 32 bits, no overflow indication
  always_comb begin
    dot_b = {{14{bprod[0][17]}}, bprod[0]} +
            {{14{bprod[1][17]}}, bprod[1]} +
            {{14{bprod[2][17]}}, bprod[2]} +
            {{14{bprod[3][17]}}, bprod[3]};
    dot_h = hprod[0][31:0] + hprod[1][31:0];
    dot_sum = (width == simd_pkg::WIDTH_HALF) ? dot_h : dot_b;
    if (accum) begin
      dot_sum = dot_sum + dest_old;
    end
  end

  always_comb begin
    res_d = dest_old;
    case (op)
      simd_pkg::OP_LANE_GET_SIGNED: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          res_d = {{16{half_pick[15]}}, half_pick};
        end else begin
          res_d = {{24{byte_pick[7]}}, byte_pick};
        end
      end
      simd_pkg::OP_LANE_GET_UNSIGNED: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          res_d = {16'h0000, half_pick};
        end else begin
          res_d = {24'h00_0000, byte_pick};
        end
      end
      simd_pkg::OP_LANE_PUT: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          res_d[16*imm[0] +: 16] = src1[15:0];
        end else begin
          res_d[8*imm[1:0] +: 8] = src1[7:0];
        end
      end
      simd_pkg::OP_DOT_UNSIGNED,
      simd_pkg::OP_DOT_MIXED_SIGN,
      simd_pkg::OP_DOT_SIGNED,
      simd_pkg::OP_DOT_ACCUM_UNSIGNED,
      simd_pkg::OP_DOT_ACCUM_MIXED_SIGN,
      simd_pkg::OP_DOT_ACCUM_SIGNED: begin
        res_d = dot_sum;
      end
      simd_pkg::OP_LANE_PERMUTE: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          res_d[31:16] = pick_half(src1, op2[`HALF_SEL_HI]);
          res_d[15:0] = pick_half(src1, op2[`HALF_SEL_LO]);
        end else begin
          res_d[31:24] = pick_byte(src1, op2[`BYTE_IDX3 +: 2]);
          res_d[23:16] = pick_byte(src1, op2[`BYTE_IDX2 +: 2]);
          res_d[15:8] = pick_byte(src1, op2[`BYTE_IDX1 +: 2]);
          res_d[7:0] = pick_byte(src1, op2[`BYTE_IDX0 +: 2]);
        end
      end
      simd_pkg::OP_LANE_PERMUTE_IMM: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          res_d[31:16] = pick_half(src1, imm[1]);
          res_d[15:0] = pick_half(src1, imm[0]);
        end else begin
          res_d[31:24] = pick_byte(src1, permute_variant);
          res_d[23:16] = pick_byte(src1, imm[`IMM_IDX2 +: 2]);
          res_d[15:8] = pick_byte(src1, imm[`IMM_IDX1 +: 2]);
          res_d[7:0] = pick_byte(src1, imm[`IMM_IDX0 +: 2]);
        end
      end
      simd_pkg::OP_TWO_SOURCE_PERMUTE: begin
        if (width == simd_pkg::WIDTH_HALF) begin
          res_d[31:16] = pick_half(op2[`HALF_SRC_HI] ? src1 : dest_old,
                                   op2[`HALF_SEL_HI]);
          res_d[15:0] = pick_half(op2[`HALF_SRC_LO] ? src1 : dest_old,
                                  op2[`HALF_SEL_LO]);
        end else begin
          res_d[31:24] = pick_byte(op2[`BYTE_SRC3] ? src1 : dest_old,
                                   op2[`BYTE_IDX3 +: 2]);
          res_d[23:16] = pick_byte(op2[`BYTE_SRC2] ? src1 : dest_old,
                                   op2[`BYTE_IDX2 +: 2]);
          res_d[15:8] = pick_byte(op2[`BYTE_SRC1] ? src1 : dest_old,
                                  op2[`BYTE_IDX1 +: 2]);
          res_d[7:0] = pick_byte(op2[`BYTE_SRC0] ? src1 : dest_old,
                                 op2[`BYTE_IDX0 +: 2]);
        end
      end
      simd_pkg::OP_HALFWORD_PACK: begin
        res_d = {src1[15:0], src2[15:0]};
      end
      simd_pkg::OP_HALFWORD_PACK_HIGH: begin
        res_d = {src1[31:16], src2[31:16]};
      end
      simd_pkg::OP_BYTE_PACK_UPPER: begin
        res_d[31:16] = {src1[7:0], src2[7:0]};
      end
      simd_pkg::OP_BYTE_PACK_LOWER: begin
        res_d[15:0] = {src1[7:0], src2[7:0]};
      end
      default: begin
        // codes past the last op leave the destination as it was
        res_d = dest_old;
      end
    endcase
  end

  // disabled extension: nothing is written back, decode sees illegal
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= op_valid & CUSTOM_EXT_ENABLE;
    end
  end

  // own flop so decode can trap without waiting on the datapath
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= op_valid & ~CUSTOM_EXT_ENABLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= `RESULT_RST_VAL;
    end else if (op_valid && CUSTOM_EXT_ENABLE) begin
      result_q <= res_d;
    end
  end
endmodule // simd_dot_shuffle_pack_unit

// [testbench/simd_unit_sva.sv]
// checker for the sub-word unit, sees top ports only
// assumes one register stage between take and answer
`timescale 1ns/1ps
module simd_unit_sva #(
  parameter bit CUSTOM_EXT_ENABLE = 1'b1
) (
  input logic mclk,
  input logic rst_n,
  input logic op_valid,
  input simd_pkg::op_t op,
  input simd_pkg::mode_t mode,
  input simd_pkg::width_t width,
  input logic [1:0] permute_variant,
  input logic [5:0] imm,
  input logic [31:0] src1,
  input logic [31:0] src2,
  input logic [31:0] dest_old,
  input logic [31:0] result_q,
  input logic result_valid_q,
  input logic illegal_q
);
  logic hv;
  logic bv;
  logic [31:0] dsh;
  logic [31:0] dub;
  logic [7:0] pb;
  logic [7:0] tb0;
  logic [7:0] gb;
  // only vector mode, so operand 2 is src2 itself
  assign hv = op_valid && mode == simd_pkg::MODE_VECTOR && !width;
  assign bv = op_valid && mode == simd_pkg::MODE_VECTOR && width;
  assign dsh = $signed(src1[15:0]) * $signed(src2[15:0])
    + $signed(src1[31:16]) * $signed(src2[31:16]);
  assign dub = src1[7:0] * src2[7:0] + src1[15:8] * src2[15:8]
    + src1[23:16] * src2[23:16] + src1[31:24] * src2[31:24];
  assign pb = src1[8*permute_variant +: 8];
  assign tb0 = src2[2] ? src1[8*src2[1:0] +: 8] : dest_old[8*src2[1:0] +: 8];
  assign gb = src1[8*imm[1:0] +: 8];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  answer_next_a:
    assert property (op_valid |=> result_valid_q == CUSTOM_EXT_ENABLE
      && illegal_q == !CUSTOM_EXT_ENABLE) else $error("answer missing");
  idle_hold_a:
    assert property (!op_valid |=> !result_valid_q && !illegal_q
      && $stable(result_q)) else $error("idle output moved");
  dot_half_a:
    assert property (hv && op == simd_pkg::OP_DOT_SIGNED
      |=> result_q == $past(dsh)) else $error("half dot wrong");
  dot_byte_a:
    assert property (bv && op == simd_pkg::OP_DOT_UNSIGNED
      |=> result_q == $past(dub)) else $error("byte dot wrong");
  put_half_a:
    assert property (hv && op == simd_pkg::OP_LANE_PUT && imm[0]
      |=> result_q == {$past(src1[15:0]), $past(dest_old[15:0])})
      else $error("lane put wrong");
  pack_keep_a:
    assert property (op_valid && op == simd_pkg::OP_BYTE_PACK_UPPER
      |=> result_q == {$past(src1[7:0]), $past(src2[7:0]),
      $past(dest_old[15:0])}) else $error("pack upper wrong");
  perm_top_a:
    assert property (bv && op == simd_pkg::OP_LANE_PERMUTE_IMM
      |=> result_q[31:24] == $past(pb)) else $error("permute top wrong");
  two_src_b0_a:
    assert property (bv && op == simd_pkg::OP_TWO_SOURCE_PERMUTE
      |=> result_q[7:0] == $past(tb0)) else $error("two source wrong");
  get_zext_a:
    assert property (bv && op == simd_pkg::OP_LANE_GET_UNSIGNED
      |=> result_q == {24'h00_0000, $past(gb)}) else $error("get wrong");
endmodule // simd_unit_sva
bind simd_dot_shuffle_pack_unit simd_unit_sva #(
  .CUSTOM_EXT_ENABLE(CUSTOM_EXT_ENABLE)
) u_sva (.mclk, .rst_n, .op_valid, .op, .mode, .width, .permute_variant,
  .imm, .src1, .src2, .dest_old, .result_q, .result_valid_q, .illegal_q);

// [testbench/operand_feeder.sv]
// operand source standing in for decode and register file
// assumes the caller enters issue at most once per cycle
`timescale 1ns/1ps
module operand_feeder (
  input logic mclk,
  output logic op_valid,
  output simd_pkg::op_t op,
  output simd_pkg::mode_t mode,
  output simd_pkg::width_t width,
  output logic imm_zext,
  output logic [1:0] permute_variant,
  output logic [5:0] imm,
  output logic [31:0] src1,
  output logic [31:0] src2,
  output logic [31:0] dest_old
);
  initial begin
    op_valid = 1'b0;
    op = simd_pkg::OP_LANE_GET_SIGNED;
    mode = simd_pkg::MODE_VECTOR;
    width = simd_pkg::WIDTH_HALF;
    {imm_zext, permute_variant, imm, src1, src2, dest_old} = '0;
  end
  task automatic issue(input simd_pkg::op_t o, input simd_pkg::mode_t m,
      input simd_pkg::width_t w, input logic [5:0] i, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] d, input logic z,
      input logic [1:0] pv);
    @(posedge mclk);
    #1;
    op_valid = 1'b1;
    op = o;
    mode = m;
    width = w;
    imm = i;
    {src1, src2, dest_old, imm_zext, permute_variant} = {a, b, d, z, pv};
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    // stale operands inverted so a late sample cannot match by luck
    {src1, src2, dest_old} = ~{a, b, d};
  endtask
endmodule // operand_feeder

// [testbench/simd_dot_shuffle_pack_unit_tb.sv]
// self-checking bench for the sub-word unit
// assumes extension enabled and the feeder as operand source
`timescale 1ns/1ps
module simd_dot_shuffle_pack_unit_tb;
  localparam logic [31:0] A = 32'h80FF_7F01;
  localparam logic [31:0] B = 32'hFF80_01FF;
  localparam logic [31:0] D = 32'h1234_5678;
  logic mclk, rst_n, op_valid, imm_zext, result_valid_q, illegal_q;
  simd_pkg::op_t op;
  simd_pkg::mode_t mode;
  simd_pkg::width_t width;
  logic [1:0] permute_variant;
  logic [5:0] imm;
  logic [31:0] src1, src2, dest_old, result_q, e;
  int err_count = 0;
  int check_count = 0;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  operand_feeder u_feed (.mclk, .op_valid, .op, .mode, .width, .imm_zext,
    .permute_variant, .imm, .src1, .src2, .dest_old);
  simd_dot_shuffle_pack_unit u_dut (.mclk, .rst_n, .op_valid, .op, .mode,
    .width, .imm_zext, .permute_variant, .imm, .src1, .src2, .dest_old,
    .result_q, .result_valid_q, .illegal_q);
  task automatic check(input string n, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [31:0] dot(input logic [31:0] a, b, d,
      input logic w, su, sv);
    logic signed [33:0] x, y;
    dot = d;
    for (int k = 0; k < (w ? 4 : 2); k++) begin
      x = w ? $signed({su & a[8*k+7], a[8*k+:8]})
        : $signed({su & a[16*k+15], a[16*k+:16]});
      y = w ? $signed({sv & b[8*k+7], b[8*k+:8]})
        : $signed({sv & b[16*k+15], b[16*k+:16]});
      dot = dot + 32'(x * y);
    end
  endfunction
  task automatic run(input simd_pkg::op_t o, input logic [1:0] m,
      input logic w, input logic [5:0] i, input logic [31:0] b, x,
      input logic z = 1'b0, input logic [1:0] pv = 2'h0);
    u_feed.issue(o, simd_pkg::mode_t'(m), simd_pkg::width_t'(w), i, A, b,
      D, z, pv);
    check("result_valid_q", {31'h0, result_valid_q}, 32'h1);
    check("illegal_q", {31'h0, illegal_q}, 32'h0);
    check(o.name(), result_q, x);
  endtask
  task automatic t_dot();
    for (int j = 0; j < 12; j++) begin
      e = dot(A, B, j % 6 > 2 ? D : 0, j > 5, j % 3 == 2, j % 3 != 0);
      run(simd_pkg::op_t'(5'(j % 6 + 3)), 0, j > 5, 0, B,
        e);
    end
    run(simd_pkg::OP_DOT_UNSIGNED, 1, 0, 0, B, dot(A, {2{B[15:0]}}, 0, 0,
      0, 0));
    run(simd_pkg::OP_DOT_SIGNED, 2, 1, 6'h2A, B, dot(A, {4{8'hEA}}, 0, 1,
      1, 1));
    run(simd_pkg::OP_DOT_SIGNED, 2, 1, 6'h2A, B, dot(A, {4{8'h2A}}, 0, 1,
      1, 1), 1'b1);
    $display("dot done");
  endtask
  task automatic t_lane();
    for (int k = 0; k < 6; k++) begin
      e = k < 4 ? {{24{A[8*k+7]}}, A[8*k+:8]}
        : {{16{A[16*k-49]}}, A[16*k-64+:16]};
      run(simd_pkg::OP_LANE_GET_SIGNED, 0, k < 4, 6'(k), B, e);
      e = k < 4 ? {24'h0, e[7:0]} : {16'h0, e[15:0]};
      run(simd_pkg::OP_LANE_GET_UNSIGNED, 0, k < 4, 6'(k), B, e);
      e = D;
      if (k < 4) e[8*k+:8] = A[7:0];
      else e[16*k-64+:16] = A[15:0];
      run(simd_pkg::OP_LANE_PUT, 0, k < 4, 6'(k), B, e);
    end
    $display("lane done");
  endtask
  task automatic t_perm();
    for (int v = 0; v < 4; v++) begin
      e = {A[8*v+:8], A[15:8], A[23:16], A[31:24]};
      run(simd_pkg::OP_LANE_PERMUTE_IMM, 0, 1, 6'h1B, B, e, 0,
        2'(v));
    end
    run(simd_pkg::OP_LANE_PERMUTE_IMM, 0, 0, 6'h01, B,
      {A[15:0], A[31:16]});
    run(simd_pkg::OP_LANE_PERMUTE, 0, 1, 0, 32'h0001_0203,
      {A[7:0], A[15:8], A[23:16], A[31:24]});
    e = {A[23:16], D[31:24], A[15:8], D[7:0]};
    run(simd_pkg::OP_TWO_SOURCE_PERMUTE, 0, 1, 0, 32'h0603_0500,
      e);
    e = {A[15:0], D[31:16]};
    run(simd_pkg::OP_TWO_SOURCE_PERMUTE, 0, 0, 0, 32'h0002_0001,
      e);
    $display("permute done");
  endtask
  task automatic t_pack();
    run(simd_pkg::OP_HALFWORD_PACK, 0, 0, 0, B, {A[15:0], B[15:0]});
    e = {A[31:16], B[31:16]};
    run(simd_pkg::OP_HALFWORD_PACK_HIGH, 0, 0, 0, B, e);
    e = {A[7:0], B[7:0], D[15:0]};
    run(simd_pkg::OP_BYTE_PACK_UPPER, 0, 1, 0, B, e);
    e = {D[31:16], A[7:0], B[7:0]};
    run(simd_pkg::OP_BYTE_PACK_LOWER, 0, 1, 0, B, e);
    $display("pack done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_dot();
    t_lane();
    t_perm();
    t_pack();
    results();
  end
  // some 45 two-cycle operations; over twelve times that before giving up
  initial begin
    #6000;
    err_count++;
    results();
  end
endmodule // simd_dot_shuffle_pack_unit_tb
